// ---- shared/tfs_defines.svh ----
// constants for the typewriter format sequencer: sizes, register offsets,
// field positions and reset values; assumes inclusion by bare name only
`ifndef TFS_DEFINES_SVH
`define TFS_DEFINES_SVH

`define TFS_NPOS       100
`define TFS_LAST_POS   7'h63
`define TFS_NLVL       5
`define TFS_NSTP       5
`define TFS_LAST_IDX   3'h4
`define TFS_NSEL       10
`define TFS_NDIST      8
`define TFS_DFAN       4

`define TFS_OFS_CTRL   32'h0000_0000
`define TFS_OFS_STAT   32'h0000_0004
`define TFS_OFS_SEL    32'h0000_0008

`define TFS_CTRL_TYPE  0
`define TFS_CTRL_ALL   1
`define TFS_CTRL_CLR   2

`define TFS_ST_POS_LSB 0
`define TFS_ST_LVL_LSB 8
`define TFS_ST_STP_LSB 12
`define TFS_ST_USED    16
`define TFS_ST_SCAN    20
`define TFS_ST_SEQ     21
`define TFS_ST_DLY     22
`define TFS_ST_ALL     23

`define TFS_RST_WORD   32'h0000_0000

`endif

// ---- shared/tfs_pkg.sv ----
// types shared by the format sequencer and its bench
// assumes tfs_defines.svh is on the include path
package tfs_pkg;
`include "tfs_defines.svh"

    typedef enum logic [2:0] {MD_IDLE, MD_SCAN, MD_SEQ, MD_DLY, MD_ALL} tfs_mode_e;

    // pulses arriving from the plugboard wiring, one cycle each
    typedef struct packed {
        logic [9:0] ent_tens;
        logic [9:0] ent_units;
        logic [4:0] ent_lvl;
        logic [4:0] ent_stp;
        logic       scan_on;
        logic       seq_on;
        logic       delay_req;
        logic       clear;
        logic       car_ret;
        logic       tab;
        logic       space;
        logic       split_req;
        logic [9:0] pick_up_input;
        logic [9:0] drop_out_input;
    } tfs_plug_in_s;

    // exits back toward the plugboard
    typedef struct packed {
        logic       col_exit_vld;
        logic [6:0] col_exit_pos;
        logic       prog_exit_vld;
        logic [2:0] prog_lvl;
        logic [2:0] prog_stp;
        logic       pause_cycle_out;
        logic [9:0] sel_xfer;
    } tfs_plug_out_s;

    // commands to the typewriter mechanism
    typedef struct packed {
        logic       type_stb;
        logic [6:0] type_pos;
        logic       car_ret;
        logic       tab;
        logic       space;
        logic       stop;
    } tfs_tw_out_s;

endpackage

// ---- design/tfs_top.sv ----
// typewriter format sequencer: position scanner, step sequencer, delay,
// selectors, distributors, carriage commands and an AHB-Lite register slave
// assumes plugboard pulses are synchronous to hclk, one hclk per character
//
// Operation
// - start position loads from one tens pulse with one units pulse
// - loading a start position turns the scanner on by itself
// - active sequencer pulses once per cycle, steps 0-4, levels A-E, wraps
// - first sequencer activation after clear emits A0
// - sequencer runs until scanner-on or a start position load
// - level plus step pulse loads sequencer start and turns it on
// - ten two-position selectors, pick-up transfers common to transfer side
// - picked selector holds until drop-out or clear
// - any control-side pulse may pick up a selector
// - clear stops, returns carriage, drops selectors, scanner 0, sequencer A0
// - clear from a scanner exit types that character first
// - scanner-on gives scanner control and stops the sequencer
// - scanner-on from sequencer: active next cycle, resumes after last position
// - sequencer-on gives sequencer control and stops the scanner
// - sequencer-on from scanner exit types first, then next step or A0
// - carriage return goes to margin; from scanner exit types first
// - tabulate at once from sequencer or delay, after character from scanner; here tab_ff delays it one cycle from every source
// - space advances carriage one, from sequencer, delay or split outputs
// - delay suspends scanner one cycle with pause pulse, then next position
// - distributor passes input to all outputs, never backward or across
// - type request starts scanner at position zero, advancing each cycle; here it starts at the held position, zero after reset, clear or type-all
// - during sequencer or delay scanner exits silent, position held
// - type-all types all 100 positions in order, ignoring other wiring
//
// Decided for this implementation: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps

module tfs_top
    import tfs_pkg::*;
#(
    parameter int NDIST = `TFS_NDIST,
    parameter int DFAN  = `TFS_DFAN
) (
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic                         hreadyout,
    output logic                         hresp,
    output logic [31:0]                  hrdata,
    input  wire tfs_plug_in_s            plug_in,
    output tfs_plug_out_s                plug_out,
    output tfs_tw_out_s                  tw_out,
    input  wire logic [NDIST-1:0]        dist_in,
    output logic [NDIST*DFAN-1:0]        dist_out
);

    ////////////////////////////////////////////////////////////////////////
    // elaboration checks

    initial begin
        if (NDIST < 1 || DFAN < 1) begin
            $error("tfs_top: distributor count and fan-out must be positive");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // declarations

    tfs_mode_e   mode_ff;
    tfs_mode_e   nxt_mode;
    logic [6:0]  pos_ff;
    logic [6:0]  nxt_pos;
    logic [2:0]  lvl_ff;
    logic [2:0]  nxt_lvl;
    logic [2:0]  stp_ff;
    logic [2:0]  nxt_stp;
    logic        used_ff;
    logic        nxt_used;
    logic [9:0]  sel_ff;
    logic        car_ret_ff;
    logic        tab_ff;
    logic        space_ff;
    logic        stop_ff;
    logic        wr_pend_ff;
    logic [31:0] wr_addr_ff;
    logic [31:0] rd_data_ff;
    logic        addr_ph;
    logic        wr_ctrl;
    logic        sw_type;
    logic        sw_all;
    logic        sw_clr;
    logic        clr_any;
    logic        wiring_on;
    logic        col_ent;
    logic        prog_ent;
    logic [6:0]  ent_pos;
    logic [31:0] stat_word;
    logic [31:0] rd_mux;

    // one-hot hub group to index; lowest hub wins if wiring drives two
    function automatic logic [3:0] hub_idx(input logic [9:0] hubs);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = 9; i >= 0; i--) begin
            if (hubs[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // ahb-lite slave: zero wait states, always OKAY

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rd_data_ff;
    assign addr_ph   = hsel & htrans[1] & hready;

    // writes land in the data phase, so keep the address one cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= `TFS_RST_WORD;
        end else begin
            wr_pend_ff <= addr_ph & hwrite;
            wr_addr_ff <= haddr;
        end
    end

    // control word bits are self-clearing commands, never stored
    assign wr_ctrl = wr_pend_ff && (wr_addr_ff == `TFS_OFS_CTRL);
    assign sw_type = wr_ctrl & hwdata[`TFS_CTRL_TYPE];
    assign sw_all  = wr_ctrl & hwdata[`TFS_CTRL_ALL];
    assign sw_clr  = wr_ctrl & hwdata[`TFS_CTRL_CLR];

    // status snapshot of scanner and sequencer state
    always_comb begin
        stat_word = `TFS_RST_WORD;
        stat_word[`TFS_ST_POS_LSB +: 7] = pos_ff;
        stat_word[`TFS_ST_LVL_LSB +: 3] = lvl_ff;
        stat_word[`TFS_ST_STP_LSB +: 3] = stp_ff;
        stat_word[`TFS_ST_USED]         = used_ff;
        stat_word[`TFS_ST_SCAN]         = (mode_ff == MD_SCAN);
        stat_word[`TFS_ST_SEQ]          = (mode_ff == MD_SEQ);
        stat_word[`TFS_ST_DLY]          = (mode_ff == MD_DLY);
        stat_word[`TFS_ST_ALL]          = (mode_ff == MD_ALL);
    end

    // read decode; unmapped addresses and the command word read zero
    always_comb begin
        if (haddr == `TFS_OFS_STAT) begin
            rd_mux = stat_word;
        end else if (haddr == `TFS_OFS_SEL) begin
            rd_mux = {22'h00_0000, sel_ff};
        end else begin
            rd_mux = `TFS_RST_WORD;
        end
    end

    // read data captured at the address phase, shown in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_data_ff <= `TFS_RST_WORD;
        end else if (addr_ph && !hwrite) begin
            rd_data_ff <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // wiring qualification

    // type-all shuts out every plugboard pulse; software clear still acts
    assign wiring_on = (mode_ff != MD_ALL);
    assign clr_any   = sw_clr | (plug_in.clear & wiring_on);
    // both hub groups must fire together to form an entry
    assign col_ent   = wiring_on & (|plug_in.ent_tens) & (|plug_in.ent_units);
    assign prog_ent  = wiring_on & (|plug_in.ent_lvl) & (|plug_in.ent_stp);
    // split request is not decoded here; wiring keeps it apart from entries
    // widen before the multiply: a 4-bit product would lose tens of 2 and up
    assign ent_pos   = 7'(hub_idx(plug_in.ent_tens)) * 7'd10
                     + 7'(hub_idx(plug_in.ent_units));

    ////////////////////////////////////////////////////////////////////////
    // scanner, sequencer and delay next state

    always_comb begin
        nxt_mode = mode_ff;
        nxt_pos  = pos_ff;
        nxt_lvl  = lvl_ff;
        nxt_stp  = stp_ff;
        nxt_used = used_ff;
        // free-running advance of whichever unit holds control
        case (mode_ff)
            MD_SCAN, MD_ALL: begin
                nxt_pos = (pos_ff == `TFS_LAST_POS) ? 7'h00 : pos_ff + 7'h01;
            end
            MD_SEQ: begin
                if (stp_ff == `TFS_LAST_IDX) begin
                    nxt_stp = 3'h0;
                    nxt_lvl = (lvl_ff == `TFS_LAST_IDX) ? 3'h0 : lvl_ff + 3'h1;
                end else begin
                    nxt_stp = stp_ff + 3'h1;
                end
            end
            MD_DLY: begin
                nxt_mode = MD_SCAN;       // position already moved on
            end
            default: begin
            end
        endcase
        if (mode_ff == MD_ALL) begin
            // stops after the last of the 100 positions
            if (pos_ff == `TFS_LAST_POS) begin
                nxt_mode = MD_IDLE;
            end
        end else begin
            if (sw_type) begin
                nxt_mode = MD_SCAN;       // starts at zero after clear
                nxt_used = 1'b1;
            end
            if (plug_in.seq_on) begin
                nxt_mode = MD_SEQ;        // held step is the next in order
            end
            if (plug_in.scan_on) begin
                nxt_mode = MD_SCAN;       // scanner emits on the next cycle
                nxt_used = 1'b1;
            end
            if (plug_in.delay_req && mode_ff == MD_SCAN) begin
                nxt_mode = MD_DLY;
            end
            if (prog_ent) begin
                nxt_lvl  = 3'(hub_idx({5'h00, plug_in.ent_lvl}));
                nxt_stp  = 3'(hub_idx({5'h00, plug_in.ent_stp}));
                nxt_mode = MD_SEQ;
            end
            if (col_ent) begin
                nxt_pos  = ent_pos;       // entry also stops the sequencer
                nxt_mode = MD_SCAN;
                nxt_used = 1'b1;
            end
        end
        if (sw_all) begin
            nxt_mode = MD_ALL;
            nxt_pos  = 7'h00;
        end
        // clear acts after the current exit has already typed
        if (clr_any) begin
            nxt_mode = MD_IDLE;
            nxt_pos  = 7'h00;
            nxt_lvl  = 3'h0;              // sequencer restarts at A0
            nxt_stp  = 3'h0;
            nxt_used = 1'b0;
        end
    end

    // control state registers, all on the one character clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_ff <= MD_IDLE;
            pos_ff  <= 7'h00;
            lvl_ff  <= 3'h0;
            stp_ff  <= 3'h0;
            used_ff <= 1'b0;
        end else begin
            mode_ff <= nxt_mode;
            pos_ff  <= nxt_pos;
            lvl_ff  <= nxt_lvl;
            stp_ff  <= nxt_stp;
            used_ff <= nxt_used;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // selectors: any plugboard pulse may drive pick-up

    for (genvar g = 0; g < `TFS_NSEL; g++) begin : g_sel
        // pick-up beats drop-out in the same cycle, clear beats both
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                sel_ff[g] <= 1'b0;
            end else if (clr_any) begin
                sel_ff[g] <= 1'b0;
            end else if (wiring_on && plug_in.pick_up_input[g]) begin
                sel_ff[g] <= 1'b1;
            end else if (wiring_on && plug_in.drop_out_input[g]) begin
                sel_ff[g] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // distributors: one-way fan-out, pure wiring so pulses keep their cycle

    for (genvar d = 0; d < NDIST; d++) begin : g_dist
        assign dist_out[d*DFAN +: DFAN] = {DFAN{dist_in[d]}};
    end

    ////////////////////////////////////////////////////////////////////////
    // carriage commands: registered, so a scanner exit types before them

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            car_ret_ff <= 1'b0;
            tab_ff     <= 1'b0;
            space_ff   <= 1'b0;
            stop_ff    <= 1'b0;
        end else begin
            car_ret_ff <= clr_any | (wiring_on & plug_in.car_ret);
            tab_ff     <= wiring_on & plug_in.tab;
            space_ff   <= wiring_on & plug_in.space;
            stop_ff    <= clr_any;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs; exits decode straight from state flops, one cycle per step

    // scanner exits fall silent while sequencer or delay holds control
    assign plug_out.col_exit_vld    = (mode_ff == MD_SCAN);
    assign plug_out.col_exit_pos    = pos_ff;
    assign plug_out.prog_exit_vld   = (mode_ff == MD_SEQ);
    assign plug_out.prog_lvl        = lvl_ff;
    assign plug_out.prog_stp        = stp_ff;
    assign plug_out.pause_cycle_out = (mode_ff == MD_DLY);
    assign plug_out.sel_xfer        = sel_ff;

    // type-all types too, but shows no column exit to the wiring
    assign tw_out.type_stb = (mode_ff == MD_SCAN) || (mode_ff == MD_ALL);
    assign tw_out.type_pos = pos_ff;
    assign tw_out.car_ret  = car_ret_ff;
    assign tw_out.tab      = tab_ff;
    assign tw_out.space    = space_ff;
    assign tw_out.stop     = stop_ff;

    // bus size and the upper haddr bits take no part beyond the compare
    logic unused_ok;
    assign unused_ok = &{1'b0, hsize, plug_in.split_req};

endmodule // tfs_top

// ---- bench/tfs_top_asserts.sv ----
// checker for the format sequencer: plug pulse timing, selectors, fan-out
// assumes it is bound into tfs_top and sees only that module's ports
`timescale 1ns/1ps

module tfs_top_chk
    import tfs_pkg::*;
#(
    parameter int NDIST = 8,
    parameter int DFAN  = 4
) (
    input wire logic                  hclk,
    input wire logic                  hresetn,
    input wire logic                  hsel,
    input wire tfs_plug_in_s          plug_in,
    input wire tfs_plug_out_s         plug_out,
    input wire tfs_tw_out_s           tw_out,
    input wire logic [NDIST-1:0]      dist_in,
    input wire logic [NDIST*DFAN-1:0] dist_out
);
    logic                  hi_pri;
    logic                  quiet;
    logic [9:0]            keep;
    logic [NDIST*DFAN-1:0] exp_fan;
    wire                   pv = plug_out.prog_exit_vld;
    wire                   cv = plug_out.col_exit_vld;
    wire  [2:0]            lv = plug_out.prog_lvl;
    wire  [2:0]            st = plug_out.prog_stp;
    wire  [6:0]            ps = plug_out.col_exit_pos;

    // entries and clear outrank every plugboard mode change
    assign hi_pri = plug_in.clear | (|plug_in.ent_tens) | (|plug_in.ent_units)
                  | (|plug_in.ent_lvl) | (|plug_in.ent_stp);
    assign quiet  = !(hi_pri | plug_in.scan_on | plug_in.seq_on | plug_in.delay_req);
    assign keep   = plug_out.sel_xfer & ~plug_in.drop_out_input;

    // each distributor output copies only its own input
    always_comb begin
        for (int i = 0; i < NDIST*DFAN; i++) begin
            exp_fan[i] = dist_in[i/DFAN];
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    ////////////////////////////////////////////////////////////////////////////
    // a bus write may act on the cycle after its address, hence !$past(hsel)
    chk_seq_step: assert property (pv && quiet && !$past(hsel) && st != 3'h4
        |=> pv && st == $past(st) + 3'h1 && lv == $past(lv)) else $error("step order");
    chk_seq_wrap: assert property (pv && quiet && !$past(hsel) && st == 3'h4
        |=> pv && st == 3'h0 && lv == ($past(lv) == 3'h4 ? 3'h0 : $past(lv) + 3'h1))
        else $error("level order");
    chk_scan_next: assert property (cv && quiet && !$past(hsel) && ps != 7'h63
        |=> cv && ps == $past(ps) + 7'h01) else $error("scanner skipped");
    chk_exit_types: assert property (cv |-> tw_out.type_stb
        && tw_out.type_pos == ps) else $error("exit without typing");
    chk_delay_slot: assert property (cv && plug_in.delay_req && !hi_pri && !$past(hsel)
        |=> plug_out.pause_cycle_out && !cv && !tw_out.type_stb) else $error("no pause");
    chk_clear_all: assert property (plug_in.clear && (cv || pv)
        |=> tw_out.stop && tw_out.car_ret && !cv && !pv && plug_out.sel_xfer == 10'h000)
        else $error("clear incomplete");
    chk_scan_on: assert property (plug_in.scan_on && pv && !hi_pri && !$past(hsel)
        |=> cv && !pv) else $error("scanner not resumed");
    chk_seq_on: assert property (plug_in.seq_on && cv && quiet == 1'h0
        && !hi_pri && !plug_in.scan_on && !plug_in.delay_req && !$past(hsel)
        |=> pv && !cv) else $error("sequencer not started");
    chk_sel_hold: assert property (!plug_in.clear && !$past(hsel)
        |=> (plug_out.sel_xfer & $past(keep)) == $past(keep)) else $error("selector lost");
    chk_sel_pick: assert property ((|plug_in.pick_up_input) && !plug_in.clear
        && !$past(hsel) && !(tw_out.type_stb && !cv)
        |=> (plug_out.sel_xfer & $past(plug_in.pick_up_input))
        == $past(plug_in.pick_up_input)) else $error("selector not picked");
    chk_ret_late: assert property (plug_in.car_ret && cv && !plug_in.clear
        |=> tw_out.car_ret) else $error("carriage return missing");
    chk_fan_out: assert property (dist_out == exp_fan) else $error("distributor leak");

    cover property (pv && lv == 3'h4 && st == 3'h4);
    cover property (plug_out.pause_cycle_out);
    cover property (tw_out.stop);
endmodule // tfs_top_chk

bind tfs_top tfs_top_chk #(.NDIST(NDIST), .DFAN(DFAN)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .plug_in(plug_in),
    .plug_out(plug_out), .tw_out(tw_out), .dist_in(dist_in), .dist_out(dist_out)
);

// ---- bench/tfs_tw_model.sv ----
// mechanism model: counts typed characters and spaces, tracks the carriage
// assumes tw_out pulses are synchronous to hclk and one cycle long
`timescale 1ns/1ps

module tfs_tw_model
    import tfs_pkg::*;
#(
    parameter int TAB_STOP = 8
) (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire tfs_tw_out_s tw_out,
    output logic [15:0]     n_typed_ff,
    output logic [7:0]      n_space_ff,
    output logic [7:0]      col_ff
);
    // totals the bench reads back
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            n_typed_ff <= '0;
            n_space_ff <= '0;
        end else begin
            n_typed_ff <= n_typed_ff + 16'(tw_out.type_stb);
            n_space_ff <= n_space_ff + 8'(tw_out.space);
        end
    end

    // carriage column; no right margin, so long lines simply keep counting
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            col_ff <= '0;
        end else if (tw_out.car_ret || tw_out.stop) begin
            col_ff <= '0;
        end else if (tw_out.tab) begin
            col_ff <= 8'((col_ff / TAB_STOP + 1) * TAB_STOP);
        end else if (tw_out.type_stb || tw_out.space) begin
            col_ff <= col_ff + 8'h01;
        end
    end
endmodule // tfs_tw_model

// ---- bench/tb_typewriter_format_sequencer.sv ----
// self-checking bench for the format sequencer over AHB-Lite and plug pulses
// assumes package, design, checker and mechanism model are compiled first
`timescale 1ns/1ps
`include "tfs_defines.svh"

module tb_typewriter_format_sequencer
    import tfs_pkg::*;
;
    logic          hclk      = 1'h0;
    logic          hresetn   = 1'h0;
    logic          hsel      = 1'h0;
    logic [31:0]   haddr     = '0;
    logic [1:0]    htrans    = '0;
    logic          hwrite    = 1'h0;
    logic [2:0]    hsize     = 3'h2;
    logic [31:0]   hwdata    = '0;
    logic          hready;
    logic          hreadyout;
    logic          hresp;
    logic [31:0]   hrdata;
    tfs_plug_in_s  plug_in   = '0;
    tfs_plug_in_s  z         = '0;
    tfs_plug_in_s  p;
    tfs_plug_out_s plug_out;
    tfs_tw_out_s   tw_out;
    logic [7:0]    dist_in   = '0;
    logic [31:0]   dist_out;
    logic [15:0]   n_typed;
    logic [15:0]   n0;
    logic [7:0]    n_space;
    logic [31:0]   q;
    int            err_count = 0;
    int            compares  = 0;
    int            cycles    = 0;

    assign hready = hreadyout;

    tfs_top #(.NDIST(8), .DFAN(4)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .plug_in(plug_in),
        .plug_out(plug_out), .tw_out(tw_out), .dist_in(dist_in), .dist_out(dist_out)
    );
    tfs_tw_model u_tw (
        .hclk(hclk), .hresetn(hresetn), .tw_out(tw_out), .n_typed_ff(n_typed),
        .n_space_ff(n_space), .col_ff()
    );

    ////////////////////////////////////////////////////////////////////////////
    // 40 MHz character clock
    initial begin
        forever #12.5 hclk = ~hclk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic summarize();
        if (err_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // one character cycle carrying the given pulses; outputs settled on return
    task automatic nx(input tfs_plug_in_s v);
        @(posedge hclk);
        plug_in <= v;
        #1;
    endtask

    // single word transfer; waits on hready, read data taken at the data edge
    task automatic ahb(input logic wr, input logic [31:0] a, d, output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'h1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'h1);
        hsel   <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'h1);
        rd = hrdata;
        #1;
    endtask

    task automatic sc(input logic [6:0] ps);
        chk("col_exit_vld", plug_out.col_exit_vld, 1'h1);
        chk("col_exit_pos", plug_out.col_exit_pos, ps);
        chk("prog_exit_vld", plug_out.prog_exit_vld, 1'h0);
    endtask

    task automatic pg(input logic [2:0] lv, input logic [2:0] st);
        chk("prog_exit_vld", plug_out.prog_exit_vld, 1'h1);
        chk("prog_lvl", plug_out.prog_lvl, lv);
        chk("prog_stp", plug_out.prog_stp, st);
        chk("col_exit_vld", plug_out.col_exit_vld, 1'h0);
    endtask

    // main sequence; each nx call is exactly one character cycle
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'h1;
        #1;
        for (int a = 0; a < 16; a += 4) begin
            ahb(1'h0, 32'(a), '0, q);
            chk("reg_reset", q, `TFS_RST_WORD);
        end
        chk("hresp", hresp, 1'h0);
        ahb(1'h1, `TFS_OFS_CTRL, 32'h0000_0001, q);
        for (int k = 0; k < 11; k++) begin
            sc(k[6:0]);
            nx(z);
        end
        p = z;
        p.car_ret = 1'h1;
        nx(p);
        chk("type_pos", tw_out.type_pos, 7'h0c);
        nx(z);
        chk("car_ret", tw_out.car_ret, 1'h1);
        p = z;
        p.delay_req = 1'h1;
        nx(p);
        nx(z);
        chk("pause", plug_out.pause_cycle_out, 1'h1);
        chk("col_silent", plug_out.col_exit_vld, 1'h0);
        nx(z);
        sc(7'h0f);
        p = z;
        p.tab = 1'h1;
        nx(p);
        nx(z);
        chk("tab", tw_out.tab, 1'h1);
        p = z;
        p.seq_on = 1'h1;
        nx(p);
        chk("type_stb", tw_out.type_stb, 1'h1);
        nx(z);
        for (int i = 0; i < 26; i++) begin
            pg(3'((i % 25) / 5), 3'(i % 5));
            nx(z);
        end
        p = z;
        p.scan_on = 1'h1;
        nx(p);
        nx(z);
        sc(7'h13);
        p = z;
        p.seq_on = 1'h1;
        nx(p);
        nx(z);
        pg(3'h0, 3'h3);
        p = z;
        p.space = 1'h1;
        nx(p);
        nx(z);
        nx(z);
        chk("spaces", n_space, 8'h01);
        p = z;
        p.ent_tens = 10'h010;
        p.ent_units = 10'h080;
        nx(p);
        nx(z);
        sc(7'h2f);
        p = z;
        p.pick_up_input = 10'h008;
        nx(p);
        nx(z);
        chk("sel_pick", plug_out.sel_xfer, 10'h008);
        p = z;
        p.pick_up_input = 10'h020;
        p.drop_out_input = 10'h008;
        nx(p);
        nx(z);
        ahb(1'h0, `TFS_OFS_SEL, '0, q);
        chk("sel_reg", q, 32'h0000_0020);
        p = z;
        p.clear = 1'h1;
        nx(p);
        chk("type_on_clear", tw_out.type_stb, 1'h1);
        nx(z);
        chk("stop", {tw_out.stop, tw_out.car_ret, plug_out.sel_xfer}, 12'hc00);
        ahb(1'h0, `TFS_OFS_STAT, '0, q);
        chk("stat_clear", q, `TFS_RST_WORD);
        p = z;
        p.ent_lvl = 5'h04;
        p.ent_stp = 5'h08;
        nx(p);
        nx(z);
        pg(3'h2, 3'h3);
        nx(z);
        nx(z);
        pg(3'h3, 3'h0);
        ahb(1'h1, `TFS_OFS_CTRL, 32'h0000_0004, q);
        p = z;
        p.seq_on = 1'h1;
        nx(p);
        nx(z);
        pg(3'h0, 3'h0);
        p = z;
        p.scan_on = 1'h1;
        nx(p);
        nx(z);
        sc(7'h00);
        p = z;
        p.clear = 1'h1;
        nx(p);
        nx(z);
        n0 = n_typed;
        ahb(1'h1, `TFS_OFS_CTRL, 32'h0000_0002, q);
        for (int k = 0; k < 100; k++) begin
            chk("all_pos", {tw_out.type_stb, plug_out.col_exit_vld, tw_out.type_pos},
                {2'h2, k[6:0]});
            nx(k == 40 ? p : z);
        end
        chk("all_done", tw_out.type_stb, 1'h0);
        chk("all_count", n_typed - n0, 16'h0064);
        for (int d = 0; d < 8; d++) begin
            @(posedge hclk);
            dist_in <= 8'h01 << d;
            #1;
            chk("dist_out", dist_out, 32'h0000_000f << (4 * d));
        end
        summarize();
    end

    // hang guard well above the few hundred cycles the sequence needs
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            summarize();
        end
    end
endmodule // tb_typewriter_format_sequencer
